//--- rtl/gr_unit.sv
// Purpose: One general register with its compare or capture logic and pin
// Assumes: Pin and counter inputs are synchronous to clk_sys_in
// Notes:   A capture beats a software write in the same cycle
`timescale 1ns/100ps
module gr_unit
    import timer_ch0_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic             clk_sys_in,
    input  wire logic             rstn_in,
    input  wire logic [FLD_W-1:0] field_in,
    input  wire logic             off_in,
    input  wire logic [CNT_W-1:0] count_in,
    input  wire logic             pin_in,
    input  wire logic             ch1_tick_in,
    input  wire logic             wr_in,
    input  wire logic [CNT_W-1:0] wdata_in,
    output logic      [CNT_W-1:0] value_out,
    output logic                  pin_out,
    output logic                  pin_oe_out,
    output gr_event_t             event_out
);
    field_t           f;
    logic             pin_q_ff;
    logic             eq_q_ff;
    logic             lvl_ff;
    logic             nxt_lvl;
    logic [FLD_W-1:0] fld_q_ff;
    logic [CNT_W-1:0] value_ff;
    logic [CNT_W-1:0] nxt_value;
    wire              rise;
    wire              fall;
    wire              eq;
    wire              is_cap;
    wire              is_cmp;
    wire              cap_hit;
    wire              match;
    wire              fld_new;

    assign f       = field_t'(field_in);
    assign is_cap  = f.capture & ~off_in;
    assign is_cmp  = ~f.capture & ~off_in;
    assign rise    = pin_in & ~pin_q_ff;
    assign fall    = ~pin_in & pin_q_ff;
    assign cap_hit = is_cap
                   & (f.alt ? ch1_tick_in : edge_hit(f.action, rise, fall)); // R8 R9 R10 R11
    assign eq      = (count_in == value_ff);
    // Only the first cycle of equality counts, so a stalled counter matches once
    assign match   = is_cmp & eq & ~eq_q_ff; // R15
    assign fld_new = (field_in != fld_q_ff);
    assign nxt_value = cap_hit ? count_in : (wr_in ? wdata_in : value_ff); // R15

    always_comb begin
        nxt_lvl = lvl_ff;
        if (fld_new) begin
            nxt_lvl = f.alt; // R5
        end else if (match) begin
            case (f.action)
                ACT_LOW:    nxt_lvl = 1'h0; // R6
                ACT_HIGH:   nxt_lvl = 1'h1; // R6
                ACT_TOGGLE: nxt_lvl = ~lvl_ff; // R7
                default:    nxt_lvl = lvl_ff;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_q_ff <= 1'h0;
            eq_q_ff  <= 1'h1;
            lvl_ff   <= 1'h0;
            fld_q_ff <= '0;
            value_ff <= '0;
        end else begin
            pin_q_ff <= pin_in;
            eq_q_ff  <= eq;
            lvl_ff   <= nxt_lvl;
            fld_q_ff <= field_in;
            value_ff <= nxt_value;
        end
    end

    assign value_out  = value_ff;
    assign pin_out    = lvl_ff;
    assign pin_oe_out = is_cmp & (f.action != ACT_OFF); // R5
    assign event_out  = '{capture: cap_hit, match: match};

    sequence s_fall_seen;
        !pin_in && $past(pin_in);
    endsequence

    chk_rise_capture: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (!off_in && field_in == CODE_CAP_RISE && rise) |=> value_ff == $past(count_in)) // R8
        else $error("rising edge not captured");
    chk_fall_capture: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (!off_in && field_in == CODE_CAP_FALL) ##0 s_fall_seen |-> cap_hit) // R9
        else $error("falling edge not captured");
    chk_both_capture: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (is_cap && !f.alt && f.action[1] && pin_in != pin_q_ff) |-> event_out.capture) // R10
        else $error("edge missed in both-edge mode");
    chk_ch1_capture: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (is_cap && f.alt && ch1_tick_in) |=> value_ff == $past(count_in)) // R11
        else $error("channel 1 tick not captured");
    chk_toggle_pin: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (match && !fld_new && f.action == ACT_TOGGLE) |=> pin_out != $past(pin_out)) // R7
        else $error("pin not toggled on match");
    chk_init_level: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (fld_new && !field_in[FLD_W-1]) |=> pin_out == $past(field_in[2])) // R5
        else $error("initial level not applied");
endmodule // gr_unit

//--- rtl/timer_ch0_io_control.sv
// Purpose: Channel 0 I/O control: compare or capture per general register
// Assumes: AXI4-Lite slave, counter and channel 1 tick supplied from outside
// Notes:   Manual reset has no port here; only rstn_in and standby_in clear
// Behaviour
// R1 - High ctrl bits 7:4 configure register B
// R2 - High ctrl bits 3:0 configure register A
// R3 - Low ctrl bits 7:4 configure register D
// R4 - Low ctrl bits 3:0 configure register C
// R5 - Top bit 0: compare, initial level, 00 off
// R6 - Codes 01/10 drive pin 0/1 on match
// R7 - Code 11 toggles pin on match
// R8 - Code 1000 captures on rising pin edge
// R9 - Code 1001 captures on falling pin edge
// R10 - Codes 1010/1011 capture on both edges
// R11 - Codes 11xx capture on channel 1 tick
// R12 - Buffer B mode silences register D
// R13 - Buffer A mode silences register C
// R14 - Power-on reset or standby clears ctrl
// R15 - Capture copies counter; match on equality
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
module timer_ch0_io_control
    import timer_ch0_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic              clk_sys_in,
    input  wire logic              rstn_in,
    input  wire logic              standby_in,
    input  wire logic [AXI_AW-1:0] s_axi_awaddr_in,
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,
    input  wire logic [31:0]       s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,
    output logic [1:0]             s_axi_bresp_out,
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    input  wire logic [AXI_AW-1:0] s_axi_araddr_in,
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,
    output logic [31:0]            s_axi_rdata_out,
    output logic [1:0]             s_axi_rresp_out,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in,
    input  wire logic [CNT_W-1:0]  count_in,
    input  wire logic              ch1_tick_in,
    input  wire logic [NUM_GR-1:0] pin_in,
    output logic      [NUM_GR-1:0] pin_out,
    output logic      [NUM_GR-1:0] pin_oe_out,
    output logic                   irq_out
);
    ////////////////////////////////////////////////////////////////////////
    logic              aw_hold_ff;
    logic              w_hold_ff;
    logic [AXI_AW-1:0] awaddr_ff;
    logic [31:0]       wdata_ff;
    logic [3:0]        wstrb_ff;
    logic              bvalid_ff;
    logic [1:0]        bresp_ff;
    logic              rvalid_ff;
    logic [31:0]       rdata_ff;
    logic [1:0]        rresp_ff;
    logic [CTRL_W-1:0] ctrl_high_ff;
    logic [CTRL_W-1:0] ctrl_low_ff;
    logic [CTRL_W-1:0] mode_ff;
    logic [IRQ_W-1:0]  irq_stat_ff;
    logic [IRQ_W-1:0]  irq_mask_ff;
    logic [CTRL_W-1:0] nxt_ctrl_high;
    logic [CTRL_W-1:0] nxt_ctrl_low;
    logic [IRQ_W-1:0]  nxt_irq_stat;
    logic [FLD_W-1:0]  fld     [NUM_GR];
    logic [CNT_W-1:0]  gr_val  [NUM_GR];
    gr_event_t         gr_ev   [NUM_GR];
    logic [NUM_GR-1:0] gr_off;
    logic [NUM_GR-1:0] gr_wr;
    logic [NUM_GR-1:0] cap_ev;
    logic [NUM_GR-1:0] match_ev;
    logic [IRQ_W-1:0]  irq_ev;
    logic [31:0]       rd_word;
    logic              rd_ok;
    wire               aw_take;
    wire               w_take;
    wire               ar_take;
    wire               do_write;
    wire               wr_ok;
    wire               w_high;
    wire               w_low;
    wire               w_mode;
    wire               w_stat;
    wire               w_mask;
    wire               w_gr;
    wire [1:0]         w_gr_idx;
    wire               r_gr;
    wire [1:0]         r_gr_idx;
    wire [31:0]        gr_merged;

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data may arrive in either order; a new
    // write is held off until the response has been taken.
    assign s_axi_awready_out = ~aw_hold_ff & ~bvalid_ff;
    assign s_axi_wready_out  = ~w_hold_ff & ~bvalid_ff;
    assign aw_take  = s_axi_awvalid_in & s_axi_awready_out;
    assign w_take   = s_axi_wvalid_in & s_axi_wready_out;
    assign do_write = aw_hold_ff & w_hold_ff;

    assign w_high   = do_write & (awaddr_ff == OFS_CTRL_HIGH);
    assign w_low    = do_write & (awaddr_ff == OFS_CTRL_LOW);
    assign w_mode   = do_write & (awaddr_ff == OFS_MODE);
    assign w_stat   = do_write & (awaddr_ff == OFS_IRQ_STAT);
    assign w_mask   = do_write & (awaddr_ff == OFS_IRQ_MASK);
    assign w_gr     = do_write & (awaddr_ff[AXI_AW-1:4] == OFS_GR_A[AXI_AW-1:4]);
    assign w_gr_idx = awaddr_ff[3:2];
    assign wr_ok    = w_high | w_low | w_mode | w_stat | w_mask | w_gr
                    | (awaddr_ff == OFS_PINS) | (awaddr_ff == OFS_COUNT);
    assign gr_merged = merge_bytes(32'(gr_val[w_gr_idx]), wdata_ff, wstrb_ff);

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            aw_hold_ff <= 1'h0;
            w_hold_ff  <= 1'h0;
            awaddr_ff  <= '0;
            wdata_ff   <= '0;
            wstrb_ff   <= '0;
            bvalid_ff  <= 1'h0;
            bresp_ff   <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_hold_ff <= 1'h1;
                awaddr_ff  <= s_axi_awaddr_in;
            end
            if (w_take) begin
                w_hold_ff <= 1'h1;
                wdata_ff  <= s_axi_wdata_in;
                wstrb_ff  <= s_axi_wstrb_in;
            end
            if (do_write) begin
                aw_hold_ff <= 1'h0;
                w_hold_ff  <= 1'h0;
                bvalid_ff  <= 1'h1;
                bresp_ff   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready_in) begin
                bvalid_ff <= 1'h0;
            end
        end
    end

    assign s_axi_bvalid_out = bvalid_ff;
    assign s_axi_bresp_out  = bresp_ff;

    ////////////////////////////////////////////////////////////////////////
    // Control registers: only byte lane 0 carries the 8-bit registers
    always_comb begin
        nxt_ctrl_high = ctrl_high_ff;
        nxt_ctrl_low  = ctrl_low_ff;
        if (standby_in) begin
            nxt_ctrl_high = CTRL_RESET; // R14
            nxt_ctrl_low  = CTRL_RESET; // R14
        end else begin
            if (w_high) begin
                nxt_ctrl_high = CTRL_W'(merge_bytes(32'(ctrl_high_ff), wdata_ff, wstrb_ff));
            end
            if (w_low) begin
                nxt_ctrl_low = CTRL_W'(merge_bytes(32'(ctrl_low_ff), wdata_ff, wstrb_ff));
            end
        end
    end

    // Write-one-to-clear; a new event in the same cycle keeps its bit set
    assign nxt_irq_stat = (irq_stat_ff & ~(w_stat && wstrb_ff[0] ?
                          wdata_ff[IRQ_W-1:0] : '0)) | irq_ev;

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_high_ff <= CTRL_RESET; // R14
            ctrl_low_ff  <= CTRL_RESET; // R14
            mode_ff      <= MODE_RESET;
            irq_stat_ff  <= '0;
            irq_mask_ff  <= '0;
        end else begin
            ctrl_high_ff <= nxt_ctrl_high;
            ctrl_low_ff  <= nxt_ctrl_low;
            irq_stat_ff  <= nxt_irq_stat;
            if (w_mode && wstrb_ff[0]) begin
                mode_ff <= wdata_ff[CTRL_W-1:0];
            end
            if (w_mask && wstrb_ff[0]) begin
                irq_mask_ff <= wdata_ff[IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field routing and buffer-mode silencing
    assign fld[0] = ctrl_high_ff[FLD_W-1:0]; // R2
    assign fld[1] = ctrl_high_ff[CTRL_W-1:FLD_W]; // R1
    assign fld[2] = ctrl_low_ff[FLD_W-1:0]; // R4
    assign fld[3] = ctrl_low_ff[CTRL_W-1:FLD_W]; // R3
    // This block makes no buffer transfer; here C and D only
    // stop capturing, matching and driving their pins.
    assign gr_off = {mode_ff[MODE_BUF_B_BIT], mode_ff[MODE_BUF_A_BIT], 2'h0}; // R12 R13

    genvar gi;
    generate
        for (gi = 0; gi < NUM_GR; gi++) begin : g_gr
            assign gr_wr[gi]    = w_gr & (w_gr_idx == 2'(gi));
            assign cap_ev[gi]   = gr_ev[gi].capture;
            assign match_ev[gi] = gr_ev[gi].match;
            gr_unit #(
                .CNT_W (CNT_W)
            ) u_gr (
                .clk_sys_in  (clk_sys_in),
                .rstn_in     (rstn_in),
                .field_in    (fld[gi]),
                .off_in      (gr_off[gi]),
                .count_in    (count_in),
                .pin_in      (pin_in[gi]),
                .ch1_tick_in (ch1_tick_in),
                .wr_in       (gr_wr[gi]),
                .wdata_in    (gr_merged[CNT_W-1:0]),
                .value_out   (gr_val[gi]),
                .pin_out     (pin_out[gi]),
                .pin_oe_out  (pin_oe_out[gi]),
                .event_out   (gr_ev[gi])
            );
        end
    endgenerate

    assign irq_ev  = {match_ev, cap_ev};
    assign irq_out = |(irq_stat_ff & irq_mask_ff);

    ////////////////////////////////////////////////////////////////////////
    // Read channel: one read at a time, answered at the edge it is taken
    assign s_axi_arready_out = ~rvalid_ff;
    assign ar_take  = s_axi_arvalid_in & s_axi_arready_out;
    assign r_gr     = s_axi_araddr_in[AXI_AW-1:4] == OFS_GR_A[AXI_AW-1:4];
    assign r_gr_idx = s_axi_araddr_in[3:2];

    always_comb begin
        rd_word = '0;
        rd_ok   = 1'h1;
        if (r_gr) begin
            rd_word = 32'(gr_val[r_gr_idx]);
        end else begin
            case (s_axi_araddr_in)
                OFS_CTRL_HIGH: rd_word = 32'(ctrl_high_ff);
                OFS_CTRL_LOW:  rd_word = 32'(ctrl_low_ff);
                OFS_MODE:      rd_word = 32'(mode_ff);
                OFS_PINS:      rd_word = 32'({pin_oe_out, pin_out});
                OFS_IRQ_STAT:  rd_word = 32'(irq_stat_ff);
                OFS_IRQ_MASK:  rd_word = 32'(irq_mask_ff);
                OFS_COUNT:     rd_word = 32'(count_in);
                default:       rd_ok   = 1'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rvalid_ff <= 1'h0;
            rdata_ff  <= '0;
            rresp_ff  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_ff <= 1'h1;
            rdata_ff  <= rd_word;
            rresp_ff  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready_in) begin
            rvalid_ff <= 1'h0;
        end
    end

    assign s_axi_rvalid_out = rvalid_ff;
    assign s_axi_rdata_out  = rdata_ff;
    assign s_axi_rresp_out  = rresp_ff;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);

    sequence s_both_taken;
        aw_take && w_take;
    endsequence

    sequence s_resp_up;
        ##[1:2] s_axi_bvalid_out;
    endsequence

    chk_write_resp: assert property (s_both_taken |-> s_resp_up)
        else $error("write response late");
    chk_oe_b_field: assert property (pin_oe_out[1] ==
        (!ctrl_high_ff[7] && ctrl_high_ff[5:4] != ACT_OFF)) // R1
        else $error("register B pin enable wrong");
    chk_oe_a_field: assert property (pin_oe_out[0] ==
        (!ctrl_high_ff[3] && ctrl_high_ff[1:0] != ACT_OFF)) // R2
        else $error("register A pin enable wrong");
    chk_oe_d_field: assert property (!mode_ff[MODE_BUF_B_BIT] |-> pin_oe_out[3] ==
        (!ctrl_low_ff[7] && ctrl_low_ff[5:4] != ACT_OFF)) // R3
        else $error("register D pin enable wrong");
    chk_oe_c_field: assert property (!mode_ff[MODE_BUF_A_BIT] |-> pin_oe_out[2] ==
        (!ctrl_low_ff[3] && ctrl_low_ff[1:0] != ACT_OFF)) // R4
        else $error("register C pin enable wrong");
    chk_buffer_d_quiet: assert property (mode_ff[MODE_BUF_B_BIT] |->
        !cap_ev[3] && !match_ev[3] && !pin_oe_out[3]) // R12
        else $error("register D active in buffer mode");
    chk_buffer_c_quiet: assert property (mode_ff[MODE_BUF_A_BIT] |->
        !cap_ev[2] && !match_ev[2] && !pin_oe_out[2]) // R13
        else $error("register C active in buffer mode");
    chk_standby_clear: assert property (standby_in |=>
        ctrl_high_ff == CTRL_RESET && ctrl_low_ff == CTRL_RESET) // R14
        else $error("standby did not clear control");
    chk_match_drive: assert property ((match_ev[0] && ctrl_high_ff[1:0] == ACT_HIGH
        && $stable(ctrl_high_ff)) |=> pin_out[0]) // R6
        else $error("pin A not driven high on match");
    chk_event_sticky: assert property (cap_ev[1] |=> irq_stat_ff[IRQ_CAP_LSB + 1])
        else $error("capture event lost");
endmodule // timer_ch0_io_control

//--- shared/timer_ch0_pkg.sv
// Purpose: Constants, field layout and helpers for the channel 0 I/O control
// Assumes: 32-bit AXI4-Lite register window, one word per register
// Notes:   Offsets are byte addresses
package timer_ch0_pkg;
    localparam int AXI_AW = 8;
    localparam int FLD_W  = 4;
    localparam int NUM_GR = 4;
    localparam int CTRL_W = 8;
    localparam logic [AXI_AW-1:0] OFS_CTRL_HIGH = 8'h00;
    localparam logic [AXI_AW-1:0] OFS_CTRL_LOW  = 8'h04;
    localparam logic [AXI_AW-1:0] OFS_MODE      = 8'h08;
    localparam logic [AXI_AW-1:0] OFS_PINS      = 8'h0c;
    localparam logic [AXI_AW-1:0] OFS_GR_A      = 8'h10;
    localparam logic [AXI_AW-1:0] OFS_IRQ_STAT  = 8'h20;
    localparam logic [AXI_AW-1:0] OFS_IRQ_MASK  = 8'h24;
    localparam logic [AXI_AW-1:0] OFS_COUNT     = 8'h28;
    localparam logic [CTRL_W-1:0] CTRL_RESET    = 8'h00;
    localparam logic [CTRL_W-1:0] MODE_RESET    = 8'h00;
    localparam int MODE_BUF_A_BIT = 4;
    localparam int MODE_BUF_B_BIT = 5;
    localparam int IRQ_CAP_LSB   = 0;
    localparam int IRQ_MATCH_LSB = 4;
    localparam int IRQ_W         = 8;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] ACT_OFF     = 2'h0;
    localparam logic [1:0] ACT_LOW     = 2'h1;
    localparam logic [1:0] ACT_HIGH    = 2'h2;
    localparam logic [1:0] ACT_TOGGLE  = 2'h3;
    localparam logic [1:0] CAP_RISE    = 2'h0;
    localparam logic [1:0] CAP_FALL    = 2'h1;
    localparam logic [FLD_W-1:0] CODE_CAP_RISE = 4'h8;
    localparam logic [FLD_W-1:0] CODE_CAP_FALL = 4'h9;

    // Bit 2 is the initial pin level in compare mode, the channel 1 source
    // select in capture mode
    typedef struct packed {
        logic       capture;
        logic       alt;
        logic [1:0] action;
    } field_t;

    typedef struct packed {
        logic capture;
        logic match;
    } gr_event_t;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic edge_hit(input logic [1:0] act, input logic rise,
        input logic fall);
        logic r;
        r = (act == CAP_RISE) ? rise : (act == CAP_FALL) ? fall : (rise | fall);
        return r;
    endfunction
endpackage

//--- test/pin_ch1_model.sv
// Purpose: Far side of channel 0: its four pins, the counter and the channel 1 tick
// Assumes: Pins are released by the model while the block drives them
// Notes:   Counter only moves while run_in is high, so captures are predictable
`timescale 1ns/100ps
module pin_ch1_model #(
    parameter int CNT_W = 8
) (
    input  wire logic             clk_sys_in,
    input  wire logic             rstn_in,
    input  wire logic             run_in,
    input  wire logic             step_in,
    input  wire logic [3:0]       lvl_in,
    input  wire logic [3:0]       oe_in,
    input  wire logic [3:0]       drv_in,
    output logic      [CNT_W-1:0] count_out,
    output logic                  tick_out,
    output logic      [3:0]       pin_out
);
    logic [CNT_W-1:0] count_ff;
    logic             tick_ff;
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_ff <= '0;
            tick_ff  <= 1'b0;
        end else begin
            count_ff <= count_ff + CNT_W'(run_in);
            tick_ff  <= step_in;
        end
    end
    assign count_out = count_ff;
    assign tick_out  = tick_ff;
    // A driven pin shows the block's level, a released one the outside level
    assign pin_out   = (oe_in & drv_in) | (~oe_in & lvl_in);
endmodule // pin_ch1_model

//--- test/tb_top.sv
// Purpose: Register-level tests of the channel 0 compare and capture control
// Assumes: AXI4-Lite master tasks, partner model for pins and counter
// Notes:   Counter is narrowed to 8 bits so a full wrap is 256 cycles
`timescale 1ns/100ps
module tb_top;
    import timer_ch0_pkg::*;
    logic        clk_sys_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic        standby = 1'b0;
    logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic        run = 1'b0, step = 1'b0;
    logic [7:0]  awa = 8'h00, ara = 8'h00, cnt, ec, ed;
    logic [31:0] wd = 32'h0, rd, got;
    logic [3:0]  lvl = 4'h0, pin, po, poe;
    logic [1:0]  br, rr, gr;
    logic        awr, wr, bv, arr, rv, irq, tick;
    int          n_mismatch = 0, n_compared = 0, cyc = 0;

    timer_ch0_io_control #(.CNT_W(8)) u_timer_ch0_io_control (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .standby_in(standby),
        .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
        .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wr), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv),
        .s_axi_bready_in(bre), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arr), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr),
        .s_axi_rvalid_out(rv), .s_axi_rready_in(rre), .count_in(cnt),
        .ch1_tick_in(tick), .pin_in(pin), .pin_out(po), .pin_oe_out(poe),
        .irq_out(irq));
    pin_ch1_model #(.CNT_W(8)) u_pin_ch1_model (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .run_in(run), .step_in(step),
        .lvl_in(lvl), .oe_in(poe), .drv_in(po), .count_out(cnt), .tick_out(tick),
        .pin_out(pin));

    initial begin
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // Handshakes are judged at the falling edge, where ready and valid are settled
    task automatic wr32(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        forever begin
            @(negedge clk_sys_in);
            ta = awv && awr;
            tw = wv && wr;
            tb = bv && bre;
            gr = br;
            @(posedge clk_sys_in);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            if (tb) begin
                bre <= 1'b0;
                break;
            end
        end
        chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, gr});
        @(posedge clk_sys_in);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ta, tr;
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        forever begin
            @(negedge clk_sys_in);
            ta = arv && arr;
            tr = rv && rre;
            got = rd;
            gr = rr;
            @(posedge clk_sys_in);
            if (ta) arv <= 1'b0;
            if (tr) begin
                rre <= 1'b0;
                break;
            end
        end
        chk($sformatf("rdata %h", a), e, got);
        chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, gr});
        @(posedge clk_sys_in);
    endtask
    task automatic wait_pin(input int k, input logic v);
        for (int i = 0; i < 600 && po[k] !== v; i++) @(negedge clk_sys_in);
        chk("match count", 32'h41, {24'h0, cnt});
        @(posedge clk_sys_in);
    endtask
    // Count moves n cycles, then stands still while the pins and tick change
    task automatic go(input int n, input logic [3:0] v, input logic t);
        run <= 1'b1;
        repeat (n) @(posedge clk_sys_in);
        run <= 1'b0;
        lvl <= v;
        step <= t;
        @(posedge clk_sys_in);
        step <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
    endtask
    task automatic irq_chk(input logic v);
        @(negedge clk_sys_in);
        chk("irq", {31'h0, v}, {31'h0, irq});
        @(posedge clk_sys_in);
    endtask
    task automatic stop_test();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        @(posedge clk_sys_in);
        rchk(OFS_CTRL_HIGH, 32'h0, RESP_OKAY);
        rchk(OFS_CTRL_LOW, 32'h0, RESP_OKAY);
        rchk(OFS_PINS, 32'h0, RESP_OKAY);
        wr32(OFS_GR_A, 32'h40, RESP_OKAY);
        wr32(OFS_GR_A + 8'h04, 32'h40, RESP_OKAY);
        wr32(OFS_CTRL_HIGH, 32'h27, RESP_OKAY);
        rchk(OFS_CTRL_HIGH, 32'h27, RESP_OKAY);
        rchk(OFS_PINS, 32'h31, RESP_OKAY);
        run <= 1'b1;
        wait_pin(1, 1'b1);
        chk("toggle a", 32'h0, {31'h0, po[0]});
        wait_pin(0, 1'b1);
        wr32(OFS_CTRL_LOW, 32'h98, RESP_OKAY);
        go(5, 4'h4, 1'b0);
        ec = cnt;
        rchk(OFS_GR_A + 8'h08, {24'h0, ec}, RESP_OKAY);
        go(5, 4'hc, 1'b0);
        go(5, 4'h4, 1'b0);
        ed = cnt;
        rchk(OFS_GR_A + 8'h0c, {24'h0, ed}, RESP_OKAY);
        go(5, 4'h8, 1'b0);
        rchk(OFS_GR_A + 8'h08, {24'h0, ec}, RESP_OKAY);
        rchk(OFS_GR_A + 8'h0c, {24'h0, ed}, RESP_OKAY);
        wr32(OFS_CTRL_LOW, 32'hca, RESP_OKAY);
        go(5, 4'h4, 1'b0);
        ec = cnt;
        rchk(OFS_GR_A + 8'h08, {24'h0, ec}, RESP_OKAY);
        rchk(OFS_GR_A + 8'h0c, {24'h0, ed}, RESP_OKAY);
        go(5, 4'h0, 1'b1);
        ed = cnt;
        ec = cnt;
        rchk(OFS_GR_A + 8'h08, {24'h0, ec}, RESP_OKAY);
        rchk(OFS_GR_A + 8'h0c, {24'h0, ed}, RESP_OKAY);
        // C and D still matched at count 0 while their output was off
        rchk(OFS_IRQ_STAT, 32'hfc, RESP_OKAY);
        wr32(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
        irq_chk(1'b0);
        wr32(OFS_IRQ_MASK, 32'h08, RESP_OKAY);
        irq_chk(1'b1);
        wr32(OFS_IRQ_STAT, 32'hfc, RESP_OKAY);
        irq_chk(1'b0);
        wr32(OFS_MODE, 32'h30, RESP_OKAY);
        wr32(OFS_CTRL_LOW, 32'h88, RESP_OKAY);
        go(5, 4'hc, 1'b0);
        rchk(OFS_GR_A + 8'h08, {24'h0, ec}, RESP_OKAY);
        rchk(OFS_GR_A + 8'h0c, {24'h0, ed}, RESP_OKAY);
        rchk(OFS_IRQ_STAT, 32'h0, RESP_OKAY);
        standby <= 1'b1;
        @(posedge clk_sys_in);
        standby <= 1'b0;
        rchk(OFS_CTRL_HIGH, 32'h0, RESP_OKAY);
        rchk(OFS_CTRL_LOW, 32'h0, RESP_OKAY);
        rchk(8'h30, 32'h0, RESP_SLVERR);
        wr32(8'h30, 32'h5, RESP_SLVERR);
        stop_test();
    end
endmodule // tb_top
